// ===== rtl/rsx_regs.vh
/*
 * Register indices, field positions and codes of the receive signaling
 * extractor. Assumes byte address = 4 * index on a 32-bit Avalon bus.
 */
// Overview of operation
// - Signaling bit is bit 8 of frames 6n
// - Codeword in slot low nibble, aligned to data
// - Extract enable copies bits into ABCD fields
// - SF stores C,D as copies of A,B
// - Signaling pin driven from stored ABCD
// - T1 DM format extracts no signaling
// - Debounce needs two identical consecutive codewords
// - T1 freezes on frame loss, slip, freeze
// - E1 also freezes on multiframe loss
// - Four-state ESF: frames 6,18 A; 12,24 B
// - Sixteen-state select stores all ABCD bits in ESF and SLC-96
// - Stored change sets channel change flag
// - Irq enable asserts interrupt on any flag
// - Indirect access by address, select, data, busy
// - E1 takes ABCD from timeslot 16
// - E1 TS0 and TS16 output is free
// - Indirect map 01-18 T1, 01-0F,11-1F E1
// - Elastic store slip freezes signaling
`ifndef RSX_REGS_VH
`define RSX_REGS_VH

`define RSX_IDX_CFG 8'hd2
`define RSX_IDX_STAT 8'hd3
`define RSX_IDX_CTL 8'hd4
`define RSX_IDX_DATA 8'hd5
`define RSX_IDX_COS0 8'hd6
`define RSX_IDX_COS1 8'hd7
`define RSX_IDX_COS2 8'hd8
`define RSX_IDX_COS3 8'hd9
`define RSX_IDX_FMT 8'hda

`define RSX_CFG_DEB 0
`define RSX_CFG_FREEZE 1
`define RSX_CFG_SIXTEEN_STATE_SELECT 2
`define RSX_CFG_SIGNALING_IRQ_ENABLE 3
`define RSX_CFG_RST 8'h00
`define RSX_STAT_BUSY 0
`define RSX_CTL_RNW 7
`define RSX_CTL_RST 8'h00
`define RSX_FMT_E1 2
`define RSX_FMT_RST 3'h0
`define RSX_ENT_EXT 4

`define RSX_F_SF 2'h0
`define RSX_F_ESF 2'h1
`define RSX_F_SLC 2'h2
`define RSX_F_DM 2'h3

`define RSX_T1_CHANS 5'h18
`define RSX_E1_SIGTS 5'h10
`define RSX_SIG_PERIOD 7'h06

`endif

// ===== rtl/rsx_chmap.v
/*
 * Maps a channel or timeslot number to its indirect entry address and
 * change flag index. Pure combinational, same clock as its user.
 */
`timescale 1ns/10ps
`include "rsx_regs.vh"

module rsx_chmap (
  e1,
  ts,
  addr,
  flag,
  ok
);
  input wire e1;
  input wire [4:0] ts;
  output wire [4:0] addr;
  output wire [4:0] flag;
  output wire ok;

  // T1 channels 0..23 sit at entries 1..24; E1 timeslot n sits at entry n
  assign addr = e1 ? ts : ts + 5'h01;
  assign flag = e1 ? ((ts < `RSX_E1_SIGTS) ? ts - 5'h01 : ts - 5'h02) : ts;
  // TS0 and TS16 carry no codeword of their own
  assign ok = e1 ? (ts != 5'h00 && ts != `RSX_E1_SIGTS)
                 : (ts < `RSX_T1_CHANS);
endmodule // rsx_chmap

// ===== rtl/rsx_top.v
/*
 * Receive signaling extractor: robbed-bit (SF/ESF/SLC-96) and E1 TS16
 * CAS extraction, debounce, freeze, change flags and signaling output.
 * Assumes the framer delivers one bit per rx_valid cycle on clk with
 * timeslot, bit position and multiframe frame number; all stream and
 * alarm inputs are synchronous to clk.
 */
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`include "rsx_regs.vh"

module rsx_top (
  clk,
  reset,
  ce,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  rx_valid,
  rx_data,
  rx_ts,
  rx_bitpos,
  rx_frame,
  loss_frame,
  loss_cas_mf,
  es_slip,
  serial_receive_data_pin,
  signaling_out_pin,
  signaling_irq
);
  input wire clk;
  input wire reset;
  input wire ce;
  input wire [9:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  input wire [3:0] avs_byteenable;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire rx_valid;
  input wire rx_data;
  input wire [4:0] rx_ts;
  input wire [2:0] rx_bitpos;
  input wire [6:0] rx_frame;
  input wire loss_frame;
  input wire loss_cas_mf;
  input wire es_slip;
  output reg serial_receive_data_pin;
  output reg signaling_out_pin;
  output reg signaling_irq;

  // ****************************************************************
  // State
  // ****************************************************************
  reg [7:0] cfg_r;
  reg [2:0] fmt_r;
  reg [7:0] ictl_r;
  reg [7:0] idat_r;
  reg busy_r;
  reg [29:0] cos_r;
  reg slip_hold_r;
  reg [3:0] e1_sh_r;
  reg [4:0] sig_mem [0:31];
  reg [3:0] prev_mem [0:31];
  reg [3:0] acc_mem [0:31];
  integer i;

  wire e1 = fmt_r[`RSX_FMT_E1];
  wire [1:0] fmt = fmt_r[1:0];
  wire deb = cfg_r[`RSX_CFG_DEB];
  wire sixteen_state_select = cfg_r[`RSX_CFG_SIXTEEN_STATE_SELECT];

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire [7:0] idx = avs_address[9:2];
  wire req = avs_read | avs_write;
  // Reads latch on the taking edge so that data stand while waitrequest
  // is low; writes land on that answer edge, when the master completes
  wire act = req & avs_waitrequest;
  wire wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire rd = act & avs_read;

  // ****************************************************************
  // T1 robbed-bit extraction
  // ****************************************************************
  wire [6:0] k_full = rx_frame / `RSX_SIG_PERIOD;
  wire [6:0] km1 = k_full - 7'h01;
  wire t1_hit = rx_valid & ~e1 & (fmt != `RSX_F_DM)
              & (rx_bitpos == 3'h7) & (rx_frame != 7'h00)
              & ((rx_frame % `RSX_SIG_PERIOD) == 7'h00);
  reg [1:0] t1_pos;
  reg t1_done;
  always @* begin
    t1_pos = km1[1:0];
    t1_done = (km1[1:0] == 2'h3);
    if (fmt == `RSX_F_SF) begin
      t1_pos = {1'b0, km1[0]};
      t1_done = (km1[1:0] == 2'h1);
    end else if (!sixteen_state_select) begin
      // Four-state: odd positions are A, even are B
      t1_pos = {1'b0, km1[0]};
    end
  end

  // ****************************************************************
  // E1 TS16 extraction
  // ****************************************************************
  wire e1_frm_ok = (rx_frame != 7'h00) && (rx_frame < 7'h10);
  wire e1_hit = rx_valid & e1 & (rx_ts == `RSX_E1_SIGTS) & e1_frm_ok;
  wire e1_done = e1_hit & rx_bitpos[1:0] == 2'h3;
  wire [3:0] e1_cw = {e1_sh_r[2:0], rx_data};
  wire [4:0] e1_ts = {rx_bitpos[2], rx_frame[3:0]};

  // ****************************************************************
  // Codeword commit
  // ****************************************************************
  wire [4:0] com_ts = e1 ? e1_ts : rx_ts;
  wire [4:0] com_addr;
  wire [4:0] com_flag;
  wire com_ok;

  rsx_chmap u_com_map (
    .e1(e1),
    .ts(com_ts),
    .addr(com_addr),
    .flag(com_flag),
    .ok(com_ok)
  );

  reg [3:0] acc_new;
  always @* begin
    acc_new = acc_mem[com_addr];
    acc_new[2'h3 - t1_pos] = rx_data;
  end

  reg [3:0] cw;
  always @* begin
    cw = e1_cw;
    if (!e1) begin
      if (fmt == `RSX_F_SF)
        cw = {acc_new[3:2], acc_new[3:2]};
      else if (!sixteen_state_select)
        cw = {acc_new[3:2], 2'h0};
      else
        cw = acc_new;
    end
  end

  wire com_valid = (e1 ? e1_done : (t1_hit & t1_done)) & com_ok;
  // Slip freezes until the next multiframe, since a slipped frame
  // may have fed part of any codeword in progress
  wire frz = cfg_r[`RSX_CFG_FREEZE] | loss_frame
           | es_slip | slip_hold_r
           | (e1 & loss_cas_mf);
  wire [4:0] cur = sig_mem[com_addr];
  wire stable = ~deb | (prev_mem[com_addr] == cw);
  wire upd = com_valid & ~frz & cur[`RSX_ENT_EXT]
           & stable & (cur[3:0] != cw);
  wire mf_start = rx_valid & (rx_ts == 5'h00) & (rx_bitpos == 3'h0)
                & (rx_frame == (e1 ? 7'h00 : 7'h01));

  // ****************************************************************
  // Indirect access
  // ****************************************************************
  wire [6:0] iaddr = ictl_r[6:0];
  wire [4:0] ia = iaddr[4:0];
  wire ia_ok = (iaddr[6:5] == 2'h0) && (ia != 5'h00)
             && (e1 ? (ia != `RSX_E1_SIGTS) : (ia <= `RSX_T1_CHANS));
  // Host access yields to a stream update of the entry array
  wire iexec = busy_r & ~upd;

  // ****************************************************************
  // Output slot lookup
  // ****************************************************************
  wire [4:0] out_addr;
  wire out_ok;

  rsx_chmap u_out_map (
    .e1(e1),
    .ts(rx_ts),
    .addr(out_addr),
    .flag(),
    .ok(out_ok)
  );

  wire [4:0] out_ent = sig_mem[out_addr];
  wire out_bit = out_ent[~rx_bitpos[1:0]];
  wire sig_nxt = out_ok & rx_bitpos[2] & out_bit;

  // ****************************************************************
  // Change flags
  // ****************************************************************
  reg [29:0] cos_set;
  reg [29:0] cos_clr;
  always @* begin
    cos_set = 30'h0;
    if (upd)
      cos_set[com_flag] = 1'b1;
    cos_clr = 30'h0;
    if (rd) begin
      case (idx)
        `RSX_IDX_COS0: cos_clr[7:0] = 8'hff;
        `RSX_IDX_COS1: cos_clr[15:8] = 8'hff;
        `RSX_IDX_COS2: cos_clr[23:16] = 8'hff;
        `RSX_IDX_COS3: cos_clr[29:24] = 6'h3f;
        default: cos_clr = 30'h0;
      endcase
    end
  end
  // Set wins over a read-clear in the same cycle
  wire [29:0] cos_nxt = (cos_r & ~cos_clr) | cos_set;

  reg [31:0] rdata_nxt;
  always @* begin
    rdata_nxt = 32'h0;
    case (idx)
      `RSX_IDX_CFG: rdata_nxt[7:0] = cfg_r;
      `RSX_IDX_STAT: rdata_nxt[`RSX_STAT_BUSY] = busy_r;
      `RSX_IDX_CTL: rdata_nxt[7:0] = ictl_r;
      `RSX_IDX_DATA: rdata_nxt[7:0] = idat_r;
      `RSX_IDX_COS0: rdata_nxt[7:0] = cos_r[7:0];
      `RSX_IDX_COS1: rdata_nxt[7:0] = cos_r[15:8];
      `RSX_IDX_COS2: rdata_nxt[7:0] = cos_r[23:16];
      `RSX_IDX_COS3: rdata_nxt[5:0] = cos_r[29:24];
      `RSX_IDX_FMT: rdata_nxt[2:0] = fmt_r;
      default: rdata_nxt = 32'h0;
    endcase
  end

  // ****************************************************************
  // Sequential logic
  // ****************************************************************
  always @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      cfg_r <= `RSX_CFG_RST;
      fmt_r <= `RSX_FMT_RST;
      ictl_r <= `RSX_CTL_RST;
      idat_r <= 8'h00;
      busy_r <= 1'b0;
      cos_r <= 30'h0;
      slip_hold_r <= 1'b0;
      e1_sh_r <= 4'h0;
      serial_receive_data_pin <= 1'b0;
      signaling_out_pin <= 1'b0;
      signaling_irq <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        sig_mem[i] <= 5'h00;
        prev_mem[i] <= 4'h0;
        acc_mem[i] <= 4'h0;
      end
    end else if (ce) begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (rd)
        avs_readdata <= rdata_nxt;
      if (wr) begin
        case (idx)
          `RSX_IDX_CFG: cfg_r <= avs_writedata[7:0];
          `RSX_IDX_FMT: fmt_r <= avs_writedata[2:0];
          default: ;
        endcase
      end
      // A new command while busy is dropped; software must poll
      if (wr && idx == `RSX_IDX_CTL && !busy_r) begin
        ictl_r <= avs_writedata[7:0];
        busy_r <= 1'b1;
      end else if (iexec) begin
        busy_r <= 1'b0;
      end
      if (iexec && ictl_r[`RSX_CTL_RNW])
        idat_r <= ia_ok ? {3'h0, sig_mem[ia]} : 8'h00;
      else if (wr && idx == `RSX_IDX_DATA)
        idat_r <= avs_writedata[7:0];
      if (upd)
        sig_mem[com_addr][3:0] <= cw;
      else if (iexec && !ictl_r[`RSX_CTL_RNW] && ia_ok)
        sig_mem[ia] <= idat_r[4:0];
      if (com_valid && !frz)
        prev_mem[com_addr] <= cw;
      if (t1_hit)
        acc_mem[com_addr] <= acc_new;
      if (e1_hit)
        e1_sh_r <= e1_cw;
      cos_r <= cos_nxt;
      if (es_slip)
        slip_hold_r <= 1'b1;
      else if (mf_start)
        slip_hold_r <= 1'b0;
      if (rx_valid) begin
        serial_receive_data_pin <= rx_data;
        signaling_out_pin <= sig_nxt;
      end
      signaling_irq <= cfg_r[`RSX_CFG_SIGNALING_IRQ_ENABLE] & (|cos_r);
    end
  end
endmodule // rsx_top

// ===== tb/rsx_monitor.sv
/* Port checker for rsx_top: bus handshake, stream timing, irq causes.
   Assumes one clock and the synchronous reset of the design. */
`timescale 1ns/10ps
module rsx_monitor (
  input wire clk,
  input wire reset,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire rx_valid,
  input wire rx_data,
  input wire [2:0] rx_bitpos,
  input wire serial_receive_data_pin,
  input wire signaling_out_pin,
  input wire signaling_irq
);
  // ********
  // Checks
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  wait_one_a: assert property (taken_s |=> !avs_waitrequest)
    else $error("no answer in one cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");
  read_high_a: assert property (taken_s ##1 avs_read
    |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
  hole_zero_a: assert property (taken_s ##0 (avs_read &&
    (avs_address[9:2] < 8'hd2 || avs_address[9:2] > 8'hda))
    |=> avs_readdata == 32'h0) else $error("unmapped read not 0");
  data_delay_a: assert property (rx_valid |=>
    serial_receive_data_pin == $past(rx_data)) else $error("data late");
  sig_low_a: assert property (rx_valid && !rx_bitpos[2] |=>
    !signaling_out_pin) else $error("signaling in upper nibble");
  reset_idle_a: assert property ($fell(reset) |->
    avs_waitrequest && !signaling_irq) else $error("not idle after reset");
  // Flags move only on a stream commit or a host access
  irq_cause_a: assert property ($changed(signaling_irq) |->
    $past(rx_valid, 2) || $past(avs_read, 2) || $past(avs_write, 2))
    else $error("irq moved");
endmodule // rsx_monitor

bind rsx_top rsx_monitor i_rsx_monitor (.*);

// ===== tb/rsx_backplane.sv
/* Backplane model: captures each slot's data byte and signaling nibble.
   Assumes it sees the framer's slot timing on the same clock. */
`timescale 1ns/10ps
module rsx_backplane (
  input wire clk,
  input wire reset,
  input wire rx_valid,
  input wire [2:0] rx_bitpos,
  input wire serial_receive_data_pin,
  input wire signaling_out_pin,
  output reg [7:0] slot_data_r,
  output reg [3:0] slot_sig_r
);
  reg valid_r;
  reg high_r;
  // ********
  // Capture, one cycle behind the slot timing
  // ********
  always @(posedge clk) begin
    valid_r <= rx_valid & ~reset;
    high_r <= rx_bitpos[2];
    if (reset) begin
      slot_data_r <= 8'h00;
      slot_sig_r <= 4'h0;
    end else if (valid_r) begin
      slot_data_r <= {slot_data_r[6:0], serial_receive_data_pin};
      if (high_r) slot_sig_r <= {slot_sig_r[2:0], signaling_out_pin};
    end
  end
endmodule // rsx_backplane

// ===== tb/tb_top.sv
/* Bench for rsx_top: Avalon tasks, framer stream driver, backplane.
   Assumes byte address = 4 * register index. */
`timescale 1ns/10ps
`include "rsx_regs.vh"
module tb_top;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [9:0] avs_address = 10'h000;
  reg [31:0] avs_writedata = 32'h0;
  reg rx_valid = 1'b0;
  reg rx_data = 1'b0;
  reg [4:0] rx_ts = 5'h00;
  reg [2:0] rx_bitpos = 3'h0;
  reg [6:0] rx_frame = 7'h00;
  reg loss_frame = 1'b0;
  reg loss_cas_mf = 1'b0;
  reg es_slip = 1'b0;
  reg [31:0] q_r;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire serial_receive_data_pin;
  wire signaling_out_pin;
  wire signaling_irq;
  wire [7:0] slot_data_r;
  wire [3:0] slot_sig_r;
  integer err_total = 0;
  integer checks = 0;
  always #5 clk = ~clk;
  // Byte lanes and clock enable stay open; alarms come from the sequence
  rsx_top i_rsx_top (
    .clk(clk),
    .reset(reset),
    .ce(1'b1),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_ts(rx_ts),
    .rx_bitpos(rx_bitpos),
    .rx_frame(rx_frame),
    .loss_frame(loss_frame),
    .loss_cas_mf(loss_cas_mf),
    .es_slip(es_slip),
    .serial_receive_data_pin(serial_receive_data_pin),
    .signaling_out_pin(signaling_out_pin),
    .signaling_irq(signaling_irq)
  );
  rsx_backplane i_rsx_backplane (.*);
  // ********
  // Tasks
  // ********
  task acc(input w, input [7:0] idx, input [7:0] d);
    begin
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_read <= ~w;
      avs_write <= w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      q_r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task rchk(input [7:0] idx, input [7:0] e);
    begin
      acc(1'b0, idx, 8'h00);
      cmp(q_r, {24'h0, e});
    end
  endtask
  task bsy;
    begin
      q_r = 32'h1;
      while (q_r[0] !== 1'b0) acc(1'b0, `RSX_IDX_STAT, 8'h00);
    end
  endtask
  task iwr(input [6:0] a, input [7:0] d);
    begin
      acc(1'b1, `RSX_IDX_DATA, d);
      acc(1'b1, `RSX_IDX_CTL, {1'b0, a});
      bsy;
    end
  endtask
  task ichk(input [6:0] a, input [7:0] e);
    begin
      acc(1'b1, `RSX_IDX_CTL, {1'b1, a});
      bsy;
      rchk(`RSX_IDX_DATA, e);
    end
  endtask
  task sb(input [4:0] t, input [2:0] b, input [6:0] f, input d);
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_ts <= t;
      rx_bitpos <= b;
      rx_frame <= f;
      rx_data <= d;
      @(posedge clk);
      rx_valid <= 1'b0;
    end
  endtask
  // Channel 0 robbed bits: frame 6k carries bit v[4-k]
  task sig(input [3:0] v, input integer n);
    integer k;
    begin
      for (k = 1; k <= n; k = k + 1) sb(5'h00, 3'h7, 7'(6 * k), v[4 - k]);
    end
  endtask
  // Slot bits go out first bit first, taken from d MSB downwards
  task slot(input [4:0] t, input integer n, input [7:0] d);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) sb(t, k[2:0], 7'h01, d[7 - k]);
      repeat (2) @(posedge clk);
    end
  endtask
  task fmt(input [7:0] f, input [7:0] c);
    begin
      acc(1'b1, `RSX_IDX_FMT, f);
      acc(1'b1, `RSX_IDX_CFG, c);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rchk(`RSX_IDX_CFG, `RSX_CFG_RST);
    rchk(8'h40, 8'h00);
    acc(1'b1, `RSX_IDX_CFG, 8'h08);
    iwr(7'h01, 8'h10);
    sig(4'ha, 2);
    ichk(7'h01, 8'h1a);
    cmp(signaling_irq, 1'b1);
    rchk(`RSX_IDX_COS0, 8'h01);
    rchk(`RSX_IDX_COS0, 8'h00);
    repeat (2) @(posedge clk);
    cmp(signaling_irq, 1'b0);
    slot(5'h00, 8, 8'h55);
    cmp(slot_data_r, 8'h55);
    cmp(slot_sig_r, 4'ha);
    acc(1'b1, `RSX_IDX_CFG, 8'h0a);
    sig(4'h5, 2);
    ichk(7'h01, 8'h1a);
    rchk(`RSX_IDX_COS0, 8'h00);
    acc(1'b1, `RSX_IDX_CFG, 8'h08);
    loss_frame <= 1'b1;
    sig(4'h5, 2);
    loss_frame <= 1'b0;
    ichk(7'h01, 8'h1a);
    // Four frames, so a format that wrongly extracts would commit
    fmt({6'h0, `RSX_F_DM}, 8'h08);
    sig(4'h5, 4);
    ichk(7'h01, 8'h1a);
    fmt({6'h0, `RSX_F_SF}, 8'h09);
    sig(4'h5, 2);
    ichk(7'h01, 8'h1a);
    sig(4'h5, 2);
    ichk(7'h01, 8'h15);
    fmt({6'h0, `RSX_F_ESF}, 8'h04);
    sig(4'h6, 4);
    ichk(7'h01, 8'h16);
    acc(1'b1, `RSX_IDX_CFG, 8'h00);
    sig(4'ha, 4);
    ichk(7'h01, 8'h18);
    fmt({6'h0, `RSX_F_SLC}, 8'h04);
    sig(4'h3, 4);
    ichk(7'h01, 8'h13);
    fmt(8'h04, 8'h00);
    iwr(7'h10, 8'h1f);
    ichk(7'h10, 8'h00);
    slot(`RSX_E1_SIGTS, 4, 8'h50);
    ichk(7'h01, 8'h15);
    slot(5'h01, 8, 8'h00);
    cmp(slot_sig_r, 4'h5);
    loss_cas_mf <= 1'b1;
    slot(`RSX_E1_SIGTS, 4, 8'ha0);
    loss_cas_mf <= 1'b0;
    ichk(7'h01, 8'h15);
    slot(`RSX_E1_SIGTS, 4, 8'ha0);
    ichk(7'h01, 8'h1a);
    // A one-cycle slip must hold the freeze until the next multiframe
    es_slip <= 1'b1;
    @(posedge clk);
    es_slip <= 1'b0;
    slot(`RSX_E1_SIGTS, 4, 8'h50);
    ichk(7'h01, 8'h1a);
    sb(5'h00, 3'h0, 7'h00, 1'b0);
    slot(`RSX_E1_SIGTS, 4, 8'h50);
    ichk(7'h01, 8'h15);
    iwr(7'h11, 8'h10);
    slot(`RSX_E1_SIGTS, 8, 8'h5a);
    ichk(7'h11, 8'h1a);
    rchk(`RSX_IDX_COS1, 8'h80);
    final_report;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    final_report;
  end
endmodule // tb_top
